// file: core/fsp_device.sv
// Function
// - Clock idle low or high both work
// - Sample input on rise, drive output on fall
// - Pause entered or left while clock low
// - Pause change waits for clock low
// - Master keeps select low to pause
// - Paused: output floats, clock and input ignored
// - Deselect while paused resets interface logic
// - Master resumes with pause high, select low
// - Status write refused if pin low, lock set
// - Status byte layout, reserved bits read zero
// - Power-up: protect bits one, others zero
// - Busy shows internal write in progress
// - Master only reads status while busy
// - Latch clear blocks program and erase
// - Latch cleared on listed completion events
// - Protect bits select blocked address area
// - Whole erase only with protect bits zero
// - Pin low and lock set freeze protection
// - Auto-increment flag shows programming mode
// - Status read repeats until deselect
// - Status write must follow enable directly
// - Master sends write enable before writes
// - Eight-bit cycles, most significant bit first
`timescale 1ns/1ps
module fsp_device (
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            reset_n,
    // Serial link
    fsp_link_if.dev              link,
    // Memory array side
    output fsp_pkg::fsp_op_t     mem_op,
    output logic                 mem_op_start,
    output logic [15:0]          mem_addr,
    output logic [7:0]           mem_data,
    output logic [7:0]           status_view
);
    import fsp_pkg::*;

    logic [4:0]  pin_raw;
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic        sck_s;
    logic        cs_s;
    logic        si_s;
    logic        hold_s;
    logic        wp_s;
    logic        sck_d;
    logic        cs_d;
    logic        paused;
    logic        act_rise;
    logic        act_fall;
    logic        exec;
    logic [2:0]  bit_cnt;
    logic [6:0]  rx_sh;
    logic [7:0]  rx_byte;
    logic [2:0]  nbytes;
    logic [7:0]  opcode;
    logic [31:0] args;
    logic        busy;
    logic [11:0] timer;
    logic        done;
    logic        write_enable_latch;
    logic [1:0]  bp;
    logic        lockdown;
    logic        auto_increment_mode;
    logic [15:0] aai_addr;
    logic        sw_armed;
    logic [7:0]  status;
    logic        so_q;
    logic        so_oe_n_q;
    logic        prot;
    logic        do_write_enable_cmd;
    logic        do_write_disable_cmd;
    logic        do_arm;
    logic        do_status_write_cmd;
    fsp_op_t     next_op;
    logic [15:0] next_addr;
    logic [7:0]  next_data;

    // Pin synchronisers
    assign pin_raw = {link.sck, link.cs_n, link.si, link.hold_n, link.wp_n};
    generate
        for (genvar i = 0; i < 5; i++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                sync1[i] <= pin_raw[i];
                sync2[i] <= sync1[i];
            end
        end
    endgenerate
    assign sck_s  = sync2[4];
    assign cs_s   = sync2[3];
    assign si_s   = sync2[2];
    assign hold_s = sync2[1];
    assign wp_s   = sync2[0];

    // Edge history
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sck_d <= 1'b0;
            cs_d  <= 1'b1;
        end else begin
            sck_d <= sck_s;
            cs_d  <= cs_s;
        end
    end

    // Pause state follows pause pin only while clock low
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            paused <= 1'b0;
        end else if (!sck_s) begin
            if (!hold_s && !cs_s) begin
                paused <= 1'b1;
            end else if (hold_s) begin
                paused <= 1'b0;
            end
        end
    end

    // Edges used only when selected and not paused
    assign act_rise = sck_s & ~sck_d & ~cs_s & ~paused;
    assign act_fall = ~sck_s & sck_d & ~cs_s & ~paused;
    assign exec     = cs_s & ~cs_d & ~paused;
    assign rx_byte  = {rx_sh, si_s};

    // Frame shifter, cleared by deselect
    always_ff @(posedge ref_clk) begin
        if (!reset_n || cs_s) begin
            bit_cnt <= 3'h0;
            rx_sh   <= 7'h00;
            nbytes  <= 3'h0;
            opcode  <= 8'h00;
            args    <= 32'h0000_0000;
        end else if (act_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_sh   <= rx_byte[6:0];
            if (bit_cnt == 3'h7) begin
                if (nbytes == 3'h0) begin
                    opcode <= rx_byte;
                end else begin
                    args <= {args[23:0], rx_byte};
                end
                if (nbytes != 3'h7) begin
                    nbytes <= nbytes + 3'h1;
                end
            end
        end
    end

    // Status byte, reserved bits zero
    always_comb begin
        status           = 8'h00;
        status[ST_BUSY]  = busy;
        status[ST_WEL]   = write_enable_latch;
        status[ST_BP_LO] = bp[0];
        status[ST_BP_HI] = bp[1];
        status[ST_AAI]   = auto_increment_mode;
        status[ST_LOCK]  = lockdown;
    end

    // Command decode at deselect on a byte boundary
    always_comb begin
        next_op   = OP_NONE;
        next_addr = args[23:8];
        next_data = args[7:0];
        do_write_enable_cmd   = 1'b0;
        do_write_disable_cmd   = 1'b0;
        do_arm    = 1'b0;
        do_status_write_cmd   = 1'b0;
        prot      = 1'b0;
        if (exec && bit_cnt == 3'h0 && !busy) begin
            case (opcode)
                OPC_WRITE_EN: begin
                    do_write_enable_cmd = (nbytes == 3'h1);
                end
                OPC_WRITE_DIS: begin
                    do_write_disable_cmd = (nbytes == 3'h1);
                end
                OPC_STATUS_WR_EN: begin
                    do_arm = (nbytes == 3'h1);
                end
                OPC_STATUS_WRITE: begin
                    do_status_write_cmd = (nbytes == 3'h2) && sw_armed && (wp_s || !lockdown);
                end
                OPC_BYTE_PROG: begin
                    if (nbytes == 3'h5 && !auto_increment_mode) begin
                        next_op = OP_BYTE_PROG;
                    end
                end
                OPC_AUTO_PROG: begin
                    if (auto_increment_mode && nbytes == 3'h2) begin
                        next_op   = OP_AUTO_PROG;
                        next_addr = aai_addr + 16'h0001;
                    end else if (!auto_increment_mode && nbytes == 3'h5) begin
                        next_op = OP_AUTO_PROG;
                    end
                end
                OPC_SECT_ERASE: begin
                    if (nbytes == 3'h4) begin
                        next_op   = OP_SECT_ERASE;
                        next_addr = args[15:0];
                    end
                end
                OPC_BLK_ERASE_A, OPC_BLK_ERASE_B: begin
                    if (nbytes == 3'h4) begin
                        next_op   = OP_BLK_ERASE;
                        next_addr = args[15:0];
                    end
                end
                OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B: begin
                    if (nbytes == 3'h1 && bp == 2'h0) begin
                        next_op = OP_CHIP_ERASE;
                    end
                end
                default: begin
                end
            endcase
            case (bp)
                2'h1: prot = (next_addr >= PROT_QTR_BASE);
                2'h2: prot = (next_addr >= PROT_HALF_BASE);
                2'h3: prot = 1'b1;
                default: prot = 1'b0;
            endcase
            if (!write_enable_latch || prot) begin
                next_op = OP_NONE;
            end
        end
    end

    // Busy timer
    assign done = busy && (timer == 12'h001);
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            busy  <= 1'b0;
            timer <= 12'h000;
        end else if (next_op != OP_NONE) begin
            busy <= 1'b1;
            case (next_op)
                OP_BYTE_PROG, OP_AUTO_PROG: timer <= PROG_CYC;
                OP_CHIP_ERASE: timer <= CHIP_CYC;
                default: timer <= ERASE_CYC;
            endcase
        end else if (busy) begin
            timer <= timer - 12'h001;
            if (done) begin
                busy <= 1'b0;
            end
        end
    end

    // Write enable latch
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            write_enable_latch <= 1'b0;
        end else if (do_write_enable_cmd) begin
            write_enable_latch <= 1'b1;
        end else if (do_write_disable_cmd || (done && (mem_op != OP_AUTO_PROG || aai_addr == ADDR_TOP))) begin
            write_enable_latch <= 1'b0;
        end
    end

    // Auto-increment mode and address
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            auto_increment_mode      <= 1'b0;
            aai_addr <= 16'h0000;
        end else if (next_op == OP_AUTO_PROG) begin
            auto_increment_mode      <= 1'b1;
            aai_addr <= next_addr;
        end else if (do_write_disable_cmd || (done && mem_op == OP_AUTO_PROG && aai_addr == ADDR_TOP)) begin
            auto_increment_mode <= 1'b0;
        end
    end

    // Protection bits and lock
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            bp       <= BP_RESET;
            lockdown <= 1'b0;
        end else if (do_status_write_cmd) begin
            bp       <= {args[ST_BP_HI], args[ST_BP_LO]};
            lockdown <= args[ST_LOCK];
        end
    end

    // Status write enable holds for one frame only
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sw_armed <= 1'b0;
        end else if (exec) begin
            sw_armed <= do_arm;
        end
    end

    // Serial output, status repeats each byte
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            so_q      <= 1'b0;
            so_oe_n_q <= 1'b1;
        end else begin
            so_oe_n_q <= ~(~cs_s & ~paused & (nbytes != 3'h0) & (opcode == OPC_STATUS_READ));
            if (act_fall) begin
                so_q <= status[3'h7 - bit_cnt];
            end
        end
    end
    assign link.so      = so_q;
    assign link.so_oe_n = so_oe_n_q;

    // Array side
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            mem_op_start <= 1'b0;
            mem_op       <= OP_NONE;
            mem_addr     <= 16'h0000;
            mem_data     <= 8'h00;
            status_view  <= 8'h00;
        end else begin
            mem_op_start <= (next_op != OP_NONE);
            status_view  <= status;
            if (next_op != OP_NONE) begin
                mem_op   <= next_op;
                mem_addr <= next_addr;
                mem_data <= next_data;
            end
        end
    end

endmodule

// file: core/fsp_host.sv
`timescale 1ns/1ps
module fsp_host (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Serial link
    fsp_link_if.host         link,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    import fsp_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_LEAD, H_SHIFT, H_TAIL} fsp_hstate_t;

    fsp_hstate_t state;
    logic [7:0]  op;
    logic [2:0]  narg;
    logic        hold_req;
    logic        wp_lvl;
    logic        mode3;
    logic [31:0] txdata;
    logic [31:0] rxdata;
    logic        wr_en;
    logic        start;
    logic [1:0]  so_sync;
    logic [3:0]  half_cnt;
    logic        adv;
    logic [5:0]  bitcnt;
    logic [5:0]  total;
    logic [2:0]  narg_p1;
    logic [39:0] txsh;
    logic        sck_q;
    logic        cs_n_q;
    logic        hold_n_q;
    logic        wp_n_q;

    // APB access
    assign wr_en = psel & penable & pready & pwrite;
    assign start = wr_en && paddr == REG_CTRL && pwdata[CTRL_GO] && state == H_IDLE;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                case (paddr)
                    REG_CTRL: prdata <= {9'h000, mode3, wp_lvl, hold_req, 1'b0, narg, op, 8'h00};
                    REG_TXDATA: prdata <= txdata;
                    REG_RXDATA: prdata <= rxdata;
                    REG_STATUS: prdata <= {31'h0000_0000, state != H_IDLE};
                    default: begin
                        prdata  <= 32'h0000_0000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Control registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            op       <= 8'h00;
            narg     <= 3'h0;
            hold_req <= 1'b0;
            wp_lvl   <= 1'b1;
            mode3    <= 1'b0;
            txdata   <= 32'h0000_0000;
        end else if (wr_en) begin
            if (paddr == REG_CTRL) begin
                op       <= pwdata[CTRL_OP +: 8];
                narg     <= pwdata[CTRL_NARG +: 3];
                hold_req <= pwdata[CTRL_HOLD];
                wp_lvl   <= pwdata[CTRL_WP];
                mode3    <= pwdata[CTRL_MODE3];
            end else if (paddr == REG_TXDATA) begin
                txdata <= pwdata;
            end
        end
    end

    // Pause and protect pins
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            hold_n_q <= 1'b1;
            wp_n_q   <= 1'b1;
            so_sync  <= 2'h0;
        end else begin
            hold_n_q <= ~hold_req;
            wp_n_q   <= wp_lvl;
            so_sync  <= {so_sync[0], link.so_line};
        end
    end

    // Clock divider, frozen while paused with clock low
    assign adv     = (half_cnt == SCK_HALF_CYC - 4'h1) & ~(hold_req & ~sck_q);
    assign narg_p1 = narg + 3'h1;
    assign total   = {narg_p1, 3'h0};

    // Frame engine
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state    <= H_IDLE;
            half_cnt <= 4'h0;
            sck_q    <= 1'b0;
            cs_n_q   <= 1'b1;
            bitcnt   <= 6'h00;
            txsh     <= 40'h00_0000_0000;
            rxdata   <= 32'h0000_0000;
        end else begin
            if (state == H_IDLE || adv || (hold_req && !sck_q)) begin
                half_cnt <= 4'h0;
            end else begin
                half_cnt <= half_cnt + 4'h1;
            end
            case (state)
                H_IDLE: begin
                    sck_q  <= mode3;
                    cs_n_q <= 1'b1;
                    if (start) begin
                        cs_n_q <= 1'b0;
                        txsh   <= {pwdata[CTRL_OP +: 8], txdata};
                        bitcnt <= 6'h00;
                        state  <= H_LEAD;
                    end
                end
                H_LEAD: begin
                    if (adv) begin
                        state <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (adv && !sck_q) begin
                        sck_q  <= 1'b1;
                        rxdata <= {rxdata[30:0], so_sync[1]};
                        bitcnt <= bitcnt + 6'h01;
                        if (mode3 && bitcnt + 6'h01 == total) begin
                            state <= H_TAIL;
                        end
                    end else if (adv) begin
                        sck_q <= 1'b0;
                        if (bitcnt == total) begin
                            state <= H_TAIL;
                        end else if (bitcnt != 6'h00) begin
                            txsh <= {txsh[38:0], 1'b0};
                        end
                    end
                end
                H_TAIL: begin
                    if (adv) begin
                        cs_n_q <= 1'b1;
                        state  <= H_IDLE;
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end

    assign link.sck    = sck_q;
    assign link.cs_n   = cs_n_q;
    assign link.si     = txsh[39];
    assign link.hold_n = hold_n_q;
    assign link.wp_n   = wp_n_q;

endmodule

// file: core/fsp_link_if.sv
`timescale 1ns/1ps
interface fsp_link_if;
    logic sck;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe_n;
    logic hold_n;
    logic wp_n;
    logic so_line;

    // Undriven data line reads low
    assign so_line = ~so_oe_n & so;

    modport dev (input sck, cs_n, si, hold_n, wp_n, output so, so_oe_n);
    modport host (output sck, cs_n, si, hold_n, wp_n, input so_line);
endinterface

// file: core/fsp_pkg.sv
package fsp_pkg;

    // Clock and serial timing
    localparam int         CLK_HZ         = 10_000_000;
    localparam logic [3:0] SCK_HALF_CYC   = 4'h8;

    // Internal write durations, microseconds, and their cycle counts
    localparam int          PROG_TIME_US  = 20;
    localparam int          ERASE_TIME_US = 100;
    localparam int          CHIP_TIME_US  = 300;
    localparam logic [11:0] PROG_CYC      = 12'(PROG_TIME_US * (CLK_HZ / 1_000_000));
    localparam logic [11:0] ERASE_CYC     = 12'(ERASE_TIME_US * (CLK_HZ / 1_000_000));
    localparam logic [11:0] CHIP_CYC      = 12'(CHIP_TIME_US * (CLK_HZ / 1_000_000));

    // Opcodes
    localparam logic [7:0] OPC_STATUS_READ  = 8'h05;
    localparam logic [7:0] OPC_STATUS_WR_EN = 8'h50;
    localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OPC_WRITE_EN     = 8'h06;
    localparam logic [7:0] OPC_WRITE_DIS    = 8'h04;
    localparam logic [7:0] OPC_BYTE_PROG    = 8'h02;
    localparam logic [7:0] OPC_AUTO_PROG    = 8'hAF;
    localparam logic [7:0] OPC_SECT_ERASE   = 8'h20;
    localparam logic [7:0] OPC_BLK_ERASE_A  = 8'h52;
    localparam logic [7:0] OPC_BLK_ERASE_B  = 8'hD8;
    localparam logic [7:0] OPC_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OPC_CHIP_ERASE_B = 8'hC7;

    // Status register layout and power-up value
    localparam int         ST_BUSY      = 0;
    localparam int         ST_WEL       = 1;
    localparam int         ST_BP_LO     = 2;
    localparam int         ST_BP_HI     = 3;
    localparam int         ST_AAI       = 6;
    localparam int         ST_LOCK      = 7;
    localparam logic [1:0] BP_RESET     = 2'h3;

    // Protected areas
    localparam logic [15:0] PROT_QTR_BASE = 16'hC000;
    localparam logic [15:0] PROT_HALF_BASE = 16'h8000;
    localparam logic [15:0] ADDR_TOP      = 16'hFFFF;

    // Controller APB registers
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_TXDATA = 8'h04;
    localparam logic [7:0] REG_RXDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam int         CTRL_GO    = 0;
    localparam int         CTRL_OP    = 8;
    localparam int         CTRL_NARG  = 16;
    localparam int         CTRL_HOLD  = 20;
    localparam int         CTRL_WP    = 21;
    localparam int         CTRL_MODE3 = 22;

    typedef enum logic [2:0] {
        OP_NONE, OP_BYTE_PROG, OP_AUTO_PROG, OP_SECT_ERASE, OP_BLK_ERASE, OP_CHIP_ERASE
    } fsp_op_t;

endpackage

// file: tb/fsp_monitor.sv
`timescale 1ns/1ps
module fsp_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Link lines
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe_n,
    input wire logic hold_n,
    input wire logic wp_n
);
    logic       sck_q;
    logic       cs_q;
    logic [7:0] rises;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Rising clock edges within a frame
    always_ff @(posedge ref_clk) begin
        sck_q <= sck;
        cs_q  <= cs_n;
    end
    always_ff @(posedge ref_clk) begin
        if (!reset_n || cs_n) begin
            rises <= 8'h00;
        end else if (sck && !sck_q && !cs_q) begin
            rises <= rises + 8'h01;
        end
    end

    a_half_period: assert property ($changed(sck) |=> $stable(sck) [*7])
        else $error("Serial clock half period too short");
    a_first_edge: assert property ($fell(cs_n) |=> $stable(sck) [*7])
        else $error("Clock edge too soon after select");
    a_si_on_low: assert property (!cs_n && !$past(cs_n) && $changed(si) |-> !sck)
        else $error("Data input changed while clock high");
    a_so_on_low: assert property (!so_oe_n && !$past(so_oe_n) && $changed(so) |-> !sck)
        else $error("Data output changed while clock high");
    a_whole_bytes: assert property ($rose(cs_n) |-> rises[2:0] == 3'h0)
        else $error("Frame ended off a byte boundary");
    a_float_deselect: assert property (cs_n [*6] |-> so_oe_n)
        else $error("Output driven while deselected");
    a_paused_float: assert property ((!hold_n && !sck && !cs_n) [*6] |-> so_oe_n)
        else $error("Output driven while paused");
    a_output_after_op: assert property ($fell(so_oe_n) |-> rises >= 8'h08)
        else $error("Output driven before opcode complete");

    c_paused: cover property ((!hold_n && !cs_n && !sck) [*6]);
    c_status_out: cover property ($fell(so_oe_n));
    c_mode3_frame: cover property ($fell(cs_n) && sck);
    c_locked_frame: cover property (!wp_n && $rose(cs_n) && si == si);
endmodule

// file: tb/serial_flash_spi_protect_status_bench.sv
`timescale 1ns/1ps
module serial_flash_spi_protect_status_bench;
    import fsp_pkg::*;
    logic        ref_clk;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    fsp_op_t     mem_op;
    logic        mem_op_start;
    logic [15:0] mem_addr;
    logic [7:0]  mem_data;
    logic [7:0]  status_view;
    logic [31:0] rd;
    logic        rd_err;
    logic        wp;
    logic        mode3;
    logic        hold_on;
    logic [7:0]  d;
    logic [26:0] nt;
    logic [26:0] notes[$];
    int          failures;
    int          checked;
    int          cycles;

    fsp_link_if link();
    fsp_host u_fsp_host (.ref_clk(ref_clk), .reset_n(reset_n), .link(link), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    fsp_device u_fsp_device (.ref_clk(ref_clk), .reset_n(reset_n), .link(link), .mem_op(mem_op),
        .mem_op_start(mem_op_start), .mem_addr(mem_addr), .mem_data(mem_data), .status_view(status_view));
    fsp_monitor u_fsp_monitor (.ref_clk(ref_clk), .reset_n(reset_n), .sck(link.sck), .cs_n(link.cs_n),
        .si(link.si), .so(link.so), .so_oe_n(link.so_oe_n), .hold_n(link.hold_n), .wp_n(link.wp_n));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("Counts: %0d checked, %0d failures", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= v;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    function automatic logic [31:0] ctrl(input logic [7:0] op, input logic [2:0] n, input logic h, input logic go);
        ctrl = {9'h0, mode3, wp, h, 1'b0, n, op, 7'h0, go};
    endfunction

    // One serial frame, optionally paused part way
    task automatic frame(input logic [7:0] op, input logic [2:0] n, input logic [31:0] a, input logic h);
        apb(1'b1, REG_TXDATA, a);
        apb(1'b1, REG_CTRL, ctrl(op, n, 1'b0, 1'b0));
        apb(1'b1, REG_CTRL, ctrl(op, n, 1'b0, 1'b1));
        if (h) begin
            repeat (150) @(posedge ref_clk);
            apb(1'b1, REG_CTRL, ctrl(op, n, 1'b1, 1'b0));
            repeat (100) @(posedge ref_clk);
            apb(1'b1, REG_CTRL, ctrl(op, n, 1'b0, 1'b0));
        end
        do apb(1'b0, REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic rd_status(input logic [7:0] exp);
        frame(OPC_STATUS_READ, 3'h2, 32'h0, hold_on);
        apb(1'b0, REG_RXDATA, 32'h0);
        check(32'(rd[15:0]), {16'h0, exp, exp});
        check(32'(status_view), 32'(exp));
    endtask

    task automatic wr_status(input logic [7:0] v);
        frame(OPC_STATUS_WR_EN, 3'h0, 32'h0, 1'b0);
        frame(OPC_STATUS_WRITE, 3'h1, {v, 24'h0}, 1'b0);
    endtask

    // Enabled write; a refused one leaves the note queue untouched
    task automatic prog(input fsp_op_t k, input logic [7:0] op, input logic [2:0] n, input logic [15:0] a,
                        input logic ok);
        d = 8'($urandom());
        frame(OPC_WRITE_EN, 3'h0, 32'h0, 1'b0);
        if (ok) notes.push_back({k, a, d});
        frame(op, n, {8'h0, a, d}, 1'b0);
        if (ok) check(32'(status_view[0]), 32'h1);
        repeat (ok ? 3010 : 10) @(posedge ref_clk);
    endtask

    // Each accepted write is matched against the oldest note
    always @(posedge ref_clk) begin
        if (reset_n === 1'b1 && mem_op_start === 1'b1) begin
            nt = (notes.size() > 0) ? notes.pop_front() : 27'h0;
            check(32'(mem_op), 32'(nt[26:24]));
            if (nt[26:24] != OP_CHIP_ERASE) check({8'h0, mem_addr, mem_data}, {8'h0, nt[23:0]});
        end
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 80000) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {reset_n, mode3, hold_on, failures, checked, cycles} = '0;
        wp = 1'b1;
        d = 8'($urandom(32'h6416));
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        rd_status(8'h0C);
        apb(1'b0, 8'h10, 32'h0);
        check(32'(rd_err), 32'h1);
        $display("Test power-up done");
        d = 8'($urandom());
        wr_status(d);
        rd_status(d & 8'h8C);
        frame(OPC_STATUS_WRITE, 3'h1, 32'h0, 1'b0);
        rd_status(d & 8'h8C);
        wr_status(8'h8C);
        wp = 1'b0;
        wr_status(8'h00);
        rd_status(8'h8C);
        wp = 1'b1;
        wr_status(8'h00);
        rd_status(8'h00);
        $display("Test status write done");
        frame(OPC_WRITE_EN, 3'h0, 32'h0, 1'b0);
        rd_status(8'h02);
        frame(OPC_WRITE_DIS, 3'h0, 32'h0, 1'b0);
        rd_status(8'h00);
        frame(OPC_BYTE_PROG, 3'h4, 32'h00001255, 1'b0);
        rd_status(8'h00);
        hold_on = 1'b1;
        rd_status(8'h00);
        mode3 = 1'b1;
        rd_status(8'h00);
        hold_on = 1'b0;
        $display("Test latch and pause done");
        for (int i = 0; i < 4; i++) begin
            wr_status({4'h0, 2'(i), 2'h0});
            prog(OP_BYTE_PROG, OPC_BYTE_PROG, 3'h4, (i == 3) ? 16'h0000 : (i == 2) ? 16'h8000 : 16'hC000, i == 0);
            prog(OP_CHIP_ERASE, i[0] ? OPC_CHIP_ERASE_B : OPC_CHIP_ERASE_A, 3'h0, 16'h0, i == 0);
            prog(OP_BYTE_PROG, OPC_BYTE_PROG, 3'h4, (i == 1) ? 16'hBFFF : (i == 2) ? 16'h7FFF : 16'hFFFF, i != 3);
            if (i != 3) rd_status({4'h0, 2'(i), 2'h0});
        end
        wr_status(8'h00);
        prog(OP_AUTO_PROG, OPC_AUTO_PROG, 3'h4, 16'hFFFE, 1'b1);
        rd_status(8'h42);
        notes.push_back({OP_AUTO_PROG, 16'hFFFF, d});
        frame(OPC_AUTO_PROG, 3'h1, {d, 24'h0}, 1'b0);
        repeat (210) @(posedge ref_clk);
        rd_status(8'h00);
        check(32'(notes.size()), 32'h0);
        $display("Test protection done");
        report_and_stop();
    end
endmodule
